// File: rtl/ccref_pkg.sv
// constants, types and decode functions for the comparator and reference control block
package ccref_pkg;

    // register indices; byte address is four times the index
    localparam logic [11:0] CMP_CTRL_IDX  = 12'h019;
    localparam logic [11:0] REF_CTRL_IDX  = 12'h099;
    localparam logic [11:0] FLAG_IDX      = 12'h0C0;

    // comparator control fields
    localparam int unsigned CMP_RESULT_BIT = 6;
    localparam int unsigned CMP_INVERT_BIT = 4;
    localparam int unsigned CMP_SWAP_BIT   = 3;
    localparam logic [7:0]  CMP_WMASK      = 8'h1F;
    localparam logic [7:0]  CMP_RESET      = 8'h00;

    // reference ladder control fields
    localparam int unsigned REF_POWER_BIT  = 7;
    localparam int unsigned REF_RANGE_BIT  = 5;
    localparam logic [7:0]  REF_WMASK      = 8'hAF;
    localparam logic [7:0]  REF_RESET      = 8'h00;

    // change flag register
    localparam int unsigned FLAG_BIT       = 0;

    // ladder level in units of supply / 96
    localparam logic [6:0]  HIGH_RANGE_BASE = 7'h18;

    // settling after a mode change
    localparam int unsigned CLK_HZ         = 10_000_000;
    localparam int unsigned MODE_SETTLE_US = 10;
    localparam int unsigned SETTLE_CNT_W   = 7;
    localparam logic [6:0]  SETTLE_CYCLES  =
        7'((MODE_SETTLE_US * CLK_HZ + 999_999) / 1_000_000);

    typedef enum logic [2:0] {
        MODE_RESET     = 3'h0,
        MODE_PAIR_OUT  = 3'h1,
        MODE_PAIR      = 3'h2,
        MODE_REF_OUT   = 3'h3,
        MODE_REF       = 3'h4,
        MODE_MUX_REF   = 3'h5,
        MODE_MUX_OUT   = 3'h6,
        MODE_OFF       = 3'h7
    } ccref_mode_t;

    typedef struct packed {
        logic comp_on;
        logic neg_from_pin0;
        logic pos_from_ref;
        logic drive_out;
        logic pin0_analog;
        logic pin1_analog;
    } ccref_route_t;

    function automatic logic [11:0] ccref_byte_addr(input logic [11:0] idx);
        ccref_byte_addr = {idx[9:0], 2'b00};
    endfunction

    function automatic logic ccref_uses_ref(input logic [2:0] mode);
        ccref_uses_ref = (mode == MODE_REF_OUT) || (mode == MODE_REF) ||
                         (mode == MODE_MUX_REF) || (mode == MODE_MUX_OUT);
    endfunction

    function automatic ccref_route_t ccref_decode(input logic [2:0] mode, input logic swap);
        ccref_route_t r;
        r = '0;
        r.comp_on      = (mode != MODE_RESET) && (mode != MODE_OFF);
        r.pos_from_ref = ccref_uses_ref(mode);
        r.drive_out    = (mode == MODE_PAIR_OUT) || (mode == MODE_REF_OUT) ||
                         (mode == MODE_MUX_OUT);
        r.neg_from_pin0 = swap && ((mode == MODE_MUX_REF) || (mode == MODE_MUX_OUT));
        r.pin1_analog  = (mode != MODE_OFF);
        r.pin0_analog  = (mode != MODE_OFF) && (mode != MODE_REF_OUT) && (mode != MODE_REF);
        ccref_decode   = r;
    endfunction

    function automatic logic [6:0] ccref_level(input logic power, input logic range,
                                               input logic [3:0] tap);
        logic [6:0] t;
        t = {3'h0, tap};
        if (!power) begin
            ccref_level = 7'h00;
        end else if (range) begin
            ccref_level = 7'(t << 2);
        end else begin
            ccref_level = 7'(HIGH_RANGE_BASE + t + t + t);
        end
    endfunction

endpackage

// File: rtl/ccref_link_if.sv
// link between the control core and the synchroniser / settle timer
`timescale 1ns/10ps
interface ccref_link_if;
    logic comp_raw;
    logic mode_change;
    logic synced;
    logic settled;

    modport core (output comp_raw, output mode_change, input synced, input settled);
    modport sync (input comp_raw, input mode_change, output synced, output settled);
endinterface

// File: rtl/ccref_settle.sv
// input synchroniser and mode-change settle timer
`timescale 1ns/10ps
module ccref_settle
    import ccref_pkg::*;
(
    // clock, reset, enable
    input wire logic     clk,
    input wire logic     rst,
    input wire logic     ce,
    // link to core
    ccref_link_if.sync   link
);

    typedef enum logic [1:0] {
        SETTLE_IDLE = 2'b00,
        SETTLE_WAIT = 2'b01
    } ccref_settle_t;

    ccref_settle_t           state_reg;
    ccref_settle_t           state_next;
    logic [SETTLE_CNT_W-1:0] cnt_reg;
    logic [SETTLE_CNT_W-1:0] cnt_next;
    logic                    meta_reg;
    logic                    sync_reg;
    logic                    settled_reg;
    logic                    settled_next;

    always_comb begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        case (state_reg)
            SETTLE_IDLE: begin
                if (link.mode_change) begin
                    state_next = SETTLE_WAIT;
                    cnt_next   = SETTLE_CYCLES - 7'h01;
                end
            end
            SETTLE_WAIT: begin
                if (link.mode_change) begin
                    cnt_next = SETTLE_CYCLES - 7'h01;
                end else if (cnt_reg == 7'h00) begin
                    state_next = SETTLE_IDLE;
                end else begin
                    cnt_next = cnt_reg - 7'h01;
                end
            end
            default: begin
                state_next = SETTLE_IDLE;
                cnt_next   = 7'h00;
            end
        endcase
        settled_next = (state_next == SETTLE_IDLE);
    end

    // [R20] two-stage synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg   <= SETTLE_IDLE;
            cnt_reg     <= 7'h00;
            meta_reg    <= 1'b0;
            sync_reg    <= 1'b0;
            settled_reg <= 1'b1;
        end else if (ce) begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            meta_reg    <= link.comp_raw;
            sync_reg    <= meta_reg;
            settled_reg <= settled_next;
        end
    end

    assign link.synced  = sync_reg;
    assign link.settled = settled_reg;

    property p_sync_delay;
        @(posedge clk) disable iff (rst)
        ce ##1 ce |=> (sync_reg == $past(link.comp_raw, 2));
    endproperty
    AST_SYNC_TWO_STAGE: assert property (p_sync_delay) // [R20]
        else $error("synchronised input does not follow raw input by two cycles");

endmodule

// File: rtl/ccref_top.sv
// comparator and reference ladder control with apb register access
// Notes on behaviour
// [R1] invert control complements the result bit
// [R2] uninverted result high when positive exceeds negative
// [R3] three-bit mode field selects eight modes
// [R4] swap bit only acts in mux modes
// [R5] result unreliable while settling after mode change
// [R6] software masks interrupts during mode change
// [R7] ladder gives 32 levels in two ranges
// [R8] low range level is tap over 24
// [R9] high range level quarter plus tap/32
// [R10] power bit turns ladder on or off
// [R11] range bit picks low or high range
// [R12] reference routed in four modes only
// [R13] unimplemented bits ignore writes, read zero
// [R14] result may drive pin two per mode
// [R15] inputs share pins zero and one
// [R16] software sets pin directions per mode
// [R17] software sets analog select before use
// [R18] change flag sets on result mismatch
// [R19] control read relatches result, ends mismatch
// [R20] raw comparator output synchronised two stages
// [R21] mode decode drives routing and enables
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
module ccref_top
    import ccref_pkg::*;
(
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // analog comparator
    input  wire logic        comp_raw,
    output logic             comparator_on,
    output logic             neg_from_pin_zero,
    output logic             pos_from_ref,
    output logic             pin_zero_analog,
    output logic             pin_one_analog,
    // pin two output
    output logic             result_pin_two_out,
    output logic             result_pin_two_oe_n,
    // reference ladder
    output logic             ladder_power_on,
    output logic             ladder_range_sel,
    output logic [3:0]       ladder_tap_sel,
    output logic [6:0]       internal_ref_level,
    // status
    output logic             comparator_result,
    output logic             result_valid,
    output logic             comparator_change_flag
);

    typedef enum logic [1:0] {
        APB_IDLE = 2'b00,
        APB_ACK  = 2'b01
    } ccref_apb_t;

    ccref_link_if link ();

    ccref_settle u_settle (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .link (link.sync)
    );

    assign link.comp_raw = comp_raw;

    // bus state
    ccref_apb_t   apb_reg;
    ccref_apb_t   apb_next;
    logic [31:0]  prdata_reg;
    logic [31:0]  prdata_next;
    logic         pslverr_reg;
    logic         pslverr_next;
    // control and status state
    logic [7:0]   cmp_ctrl_reg;
    logic [7:0]   cmp_ctrl_next;
    logic [7:0]   ref_ctrl_reg;
    logic [7:0]   ref_ctrl_next;
    logic         result_reg;
    logic         result_next;
    logic         latched_reg;
    logic         latched_next;
    logic         flag_reg;
    logic         flag_next;
    logic         valid_reg;
    // registered outputs
    ccref_route_t route_reg;
    ccref_route_t route_next;
    logic [6:0]   level_reg;
    logic [6:0]   level_next;
    // decode helpers
    logic         done;
    logic         hit_cmp;
    logic         hit_ref;
    logic         hit_flag;
    logic [7:0]   rd_byte;
    logic         mismatch;

    // bus decode and register file
    always_comb begin
        apb_next      = apb_reg;
        prdata_next   = prdata_reg;
        pslverr_next  = pslverr_reg;
        cmp_ctrl_next = cmp_ctrl_reg;
        ref_ctrl_next = ref_ctrl_reg;
        latched_next  = latched_reg;
        flag_next     = flag_reg;
        hit_cmp       = (paddr == ccref_byte_addr(CMP_CTRL_IDX));
        hit_ref       = (paddr == ccref_byte_addr(REF_CTRL_IDX));
        hit_flag      = (paddr == ccref_byte_addr(FLAG_IDX));
        done          = (apb_reg == APB_ACK) && psel && penable;
        link.mode_change = 1'b0;
        // [R13] unimplemented bits read zero
        rd_byte = 8'h00;
        if (hit_cmp) begin
            rd_byte = cmp_ctrl_reg & CMP_WMASK;
            rd_byte[CMP_RESULT_BIT] = result_reg;
        end else if (hit_ref) begin
            rd_byte = ref_ctrl_reg & REF_WMASK;
        end else if (hit_flag) begin
            rd_byte[FLAG_BIT] = flag_reg;
        end
        case (apb_reg)
            APB_IDLE: begin
                if (psel && !penable) begin
                    apb_next     = APB_ACK;
                    prdata_next  = {24'h000000, rd_byte};
                    pslverr_next = !(hit_cmp || hit_ref || hit_flag);
                end
            end
            APB_ACK: begin
                if (done) begin
                    apb_next     = APB_IDLE;
                    prdata_next  = 32'h00000000;
                    pslverr_next = 1'b0;
                end
            end
            default: begin
                apb_next = APB_IDLE;
            end
        endcase
        if (done && pwrite) begin
            // [R13] writes masked to implemented bits
            if (hit_cmp) begin
                // [R3] mode field stored
                cmp_ctrl_next = pwdata[7:0] & CMP_WMASK;
                latched_next  = result_reg;
                link.mode_change = (pwdata[2:0] != cmp_ctrl_reg[2:0]);
            end
            if (hit_ref) begin
                ref_ctrl_next = pwdata[7:0] & REF_WMASK;
            end
            if (hit_flag) begin
                flag_next = pwdata[FLAG_BIT];
            end
        end
        // [R19] control read relatches shown result
        if (done && !pwrite && hit_cmp) begin
            latched_next = prdata_reg[CMP_RESULT_BIT];
        end
        // [R18] mismatch sets flag over a clear
        mismatch = (result_reg != latched_reg) && link.settled;
        if (mismatch) begin
            flag_next = 1'b1;
        end
    end

    // result, routing and ladder outputs
    always_comb begin
        // [R1] [R2] polarity applied after synchroniser
        result_next = link.synced ^ cmp_ctrl_reg[CMP_INVERT_BIT];
        // [R4] [R21] mode decode to routing
        route_next  = ccref_decode(cmp_ctrl_reg[2:0], cmp_ctrl_reg[CMP_SWAP_BIT]);
        // [R7] [R8] [R9] ladder level from range and tap
        level_next  = ccref_level(ref_ctrl_reg[REF_POWER_BIT], ref_ctrl_reg[REF_RANGE_BIT],
                                  ref_ctrl_reg[3:0]);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            apb_reg      <= APB_IDLE;
            prdata_reg   <= 32'h00000000;
            pslverr_reg  <= 1'b0;
            cmp_ctrl_reg <= CMP_RESET;
            ref_ctrl_reg <= REF_RESET;
            latched_reg  <= 1'b0;
            flag_reg     <= 1'b0;
            result_reg   <= 1'b0;
            route_reg    <= '0;
            level_reg    <= 7'h00;
            valid_reg    <= 1'b1;
        end else if (ce) begin
            apb_reg      <= apb_next;
            prdata_reg   <= prdata_next;
            pslverr_reg  <= pslverr_next;
            cmp_ctrl_reg <= cmp_ctrl_next;
            ref_ctrl_reg <= ref_ctrl_next;
            latched_reg  <= latched_next;
            flag_reg     <= flag_next;
            result_reg   <= result_next;
            route_reg    <= route_next;
            level_reg    <= level_next;
            // [R5] validity withdrawn while settling
            valid_reg    <= link.settled;
        end
    end

    assign prdata                 = prdata_reg;
    assign pready                 = (apb_reg == APB_ACK);
    assign pslverr                = pslverr_reg;
    assign comparator_on          = route_reg.comp_on;
    // [R15] pin sharing from mode decode
    assign neg_from_pin_zero      = route_reg.neg_from_pin0;
    // [R12] reference in four modes
    assign pos_from_ref           = route_reg.pos_from_ref;
    assign pin_zero_analog        = route_reg.pin0_analog;
    assign pin_one_analog         = route_reg.pin1_analog;
    // [R14] pin two follows result when enabled
    assign result_pin_two_out     = result_reg;
    assign result_pin_two_oe_n    = !route_reg.drive_out;
    // [R10] power and [R11] range straight from control
    assign ladder_power_on        = ref_ctrl_reg[REF_POWER_BIT];
    assign ladder_range_sel       = ref_ctrl_reg[REF_RANGE_BIT];
    assign ladder_tap_sel         = ref_ctrl_reg[3:0];
    assign internal_ref_level     = level_reg;
    assign comparator_result      = result_reg;
    assign result_valid           = valid_reg;
    assign comparator_change_flag = flag_reg;

    sequence seq_mode_write;
        done && pwrite && hit_cmp && (pwdata[2:0] != cmp_ctrl_reg[2:0]) && ce;
    endsequence

    sequence seq_invalid_hold;
        ##1 (!valid_reg) [*4];
    endsequence

    AST_INVERT_APPLIED: assert property (@(posedge clk) disable iff (rst) // [R1]
        ce && cmp_ctrl_reg[CMP_INVERT_BIT] |=> (result_reg == !$past(link.synced)))
        else $error("inverted result is not the complement");

    AST_RESULT_RAW: assert property (@(posedge clk) disable iff (rst) // [R2]
        ce && !cmp_ctrl_reg[CMP_INVERT_BIT] |=> (result_reg == $past(link.synced)))
        else $error("uninverted result differs from comparison");

    AST_MODE_FIELD: assert property (@(posedge clk) disable iff (rst) // [R3]
        done && pwrite && hit_cmp && ce |=> (cmp_ctrl_reg[2:0] == $past(pwdata[2:0])))
        else $error("mode field not taken from write data");

    AST_SWAP_ONLY_MUX: assert property (@(posedge clk) disable iff (rst) // [R4]
        $rose(neg_from_pin_zero) |-> $past(cmp_ctrl_reg[CMP_SWAP_BIT]) &&
            (($past(cmp_ctrl_reg[2:0]) == 3'h5) || ($past(cmp_ctrl_reg[2:0]) == 3'h6)))
        else $error("negative input swapped outside mux modes");

    AST_SETTLE_INVALID: assert property (@(posedge clk) disable iff (rst) // [R5]
        seq_mode_write |=> seq_invalid_hold)
        else $error("result valid too soon after mode change");

    AST_LOW_RANGE: assert property (@(posedge clk) disable iff (rst) // [R8]
        ce && ladder_power_on && ladder_range_sel |=>
            (internal_ref_level == {1'b0, $past(ladder_tap_sel), 2'b00}))
        else $error("low range level wrong");

    AST_HIGH_RANGE: assert property (@(posedge clk) disable iff (rst) // [R9]
        ce && ladder_power_on && !ladder_range_sel |=>
            (internal_ref_level == 7'(7'd24 + 7'd3 * {3'h0, $past(ladder_tap_sel)})))
        else $error("high range level wrong");

    AST_POWER_OFF: assert property (@(posedge clk) disable iff (rst) // [R10]
        ce && !ladder_power_on |=> (internal_ref_level == 7'h00))
        else $error("ladder level present while powered off");

    AST_REF_MODES: assert property (@(posedge clk) disable iff (rst) // [R12]
        $rose(pos_from_ref) |-> ($past(cmp_ctrl_reg[2:0]) inside {3'h3, 3'h4, 3'h5, 3'h6}))
        else $error("reference routed in a mode without it");

    AST_UNIMPL_ZERO: assert property (@(posedge clk) disable iff (rst) // [R13]
        pready && hit_cmp |-> (prdata[31:7] == 25'h0000000) && !prdata[5])
        else $error("unimplemented bits read nonzero");

    AST_PIN_TWO: assert property (@(posedge clk) disable iff (rst) // [R14]
        !result_pin_two_oe_n |-> (result_pin_two_out == comparator_result) && comparator_on)
        else $error("pin two driven with wrong value or mode");

    AST_FLAG_SETS: assert property (@(posedge clk) disable iff (rst) // [R18]
        ce && (result_reg != latched_reg) && link.settled |=> comparator_change_flag)
        else $error("change flag not set on mismatch");

    AST_READ_RELATCH: assert property (@(posedge clk) disable iff (rst) // [R19]
        ce && done && !pwrite && hit_cmp |=> (latched_reg == $past(prdata[CMP_RESULT_BIT])))
        else $error("control read did not relatch result");

endmodule

// File: tb/tb_ccref_top.sv
// self-checking bench for the comparator and reference ladder control block
`timescale 1ns/10ps
module tb_ccref_top import ccref_pkg::*;;
    localparam logic [11:0] A_CMP  = {CMP_CTRL_IDX[9:0], 2'b00};
    localparam logic [11:0] A_REF  = {REF_CTRL_IDX[9:0], 2'b00};
    localparam logic [11:0] A_FLAG = {FLAG_IDX[9:0], 2'b00};
    localparam int          LIMIT  = 20000;

    logic        clk, rst, ce, psel, penable, pwrite, comp_raw, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        comparator_on, neg_from_pin_zero, pos_from_ref, pin_zero_analog;
    logic        pin_one_analog, result_pin_two_out, result_pin_two_oe_n;
    logic        ladder_power_on, ladder_range_sel, comparator_result, result_valid;
    logic        comparator_change_flag;
    logic [3:0]  ladder_tap_sel;
    logic [6:0]  internal_ref_level;
    int          n_errors, checked, cyc;

    ccref_top u_dut (
        .clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .comp_raw, .comparator_on, .neg_from_pin_zero, .pos_from_ref,
        .pin_zero_analog, .pin_one_analog, .result_pin_two_out, .result_pin_two_oe_n,
        .ladder_power_on, .ladder_range_sel, .ladder_tap_sel, .internal_ref_level,
        .comparator_result, .result_valid, .comparator_change_flag
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_errors++;
            report_and_stop();
        end
    end

    function automatic logic [6:0] exp_level(input logic p, input logic r, input logic [3:0] t);
        if (!p) return 7'h00;
        return r ? {1'b0, t, 2'b00} : 7'h18 + 7'h03 * {3'h0, t};
    endfunction

    // {on, neg from pin 0, pos from ladder, pin two oe_n, pin 0 analog, pin 1 analog}
    function automatic logic [5:0] exp_route(input logic [2:0] m, input logic sw);
        logic ref_on;
        ref_on = m inside {3'h3, 3'h4, 3'h5, 3'h6};
        return {m != 3'h0 && m != 3'h7, sw && (m inside {3'h5, 3'h6}), ref_on,
                !(m inside {3'h1, 3'h3, 3'h6}), m != 3'h7 && !(m inside {3'h3, 3'h4}),
                m != 3'h7};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // pready sampled at the rising edge that completes the access
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_errors++;
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd, er);
        chk(rd, exp);
        chk({31'h0, er}, 32'h0);
    endtask

    task automatic settle(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((result_valid !== 1'b1 || n < 4) && n < 300);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        logic [31:0] wd;
        logic [31:0] last_ref;
        logic        inv, raw;
        int          n;
        void'($urandom(32'hB5EC51E1));
        rst = 1'b1; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; comp_raw = 1'b0;
        n_errors = 0; checked = 0; cyc = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({result_pin_two_oe_n, result_valid, comparator_change_flag, comparator_on,
             ladder_power_on}, 32'h18);
        rd_chk(A_CMP, {24'h0, CMP_RESET});
        rd_chk(A_REF, {24'h0, REF_RESET});
        $display("test reset done");
        for (int i = 0; i < 32; i++) begin
            wd = $urandom;
            wd[5] = i[4];
            wd[3:0] = i[3:0];
            apb(1'b1, A_REF, wd, rd, er);
            rd_chk(A_REF, {24'h0, wd[7:0] & REF_WMASK});
            chk({ladder_power_on, ladder_range_sel, ladder_tap_sel, internal_ref_level},
                {wd[7], wd[5], wd[3:0], exp_level(wd[7], wd[5], wd[3:0])});
        end
        last_ref = wd;
        $display("test ladder done");
        for (int i = 0; i < 16; i++) begin
            wd = $urandom;
            wd[3:0] = i[3:0];
            apb(1'b1, A_CMP, wd, rd, er);
            repeat (2) @(negedge clk);
            chk({comparator_on, neg_from_pin_zero, pos_from_ref, result_pin_two_oe_n,
                 pin_zero_analog, pin_one_analog}, exp_route(wd[2:0], wd[3]));
            rd_chk(A_CMP, {24'h0, wd[7:0] & CMP_WMASK} | {25'h0, wd[4], 6'h0});
        end
        $display("test modes done");
        for (int i = 0; i < 8; i++) begin
            raw = 1'($urandom);
            inv = i[0];
            @(posedge clk);
            comp_raw <= raw;
            apb(1'b1, A_CMP, {27'h0, inv, 4'h2}, rd, er);
            repeat (4) @(negedge clk);
            chk({comparator_result, result_pin_two_out}, {2{raw ^ inv}});
            rd_chk(A_CMP, {25'h0, raw ^ inv, 1'b0, inv, 4'h2});
            @(posedge clk);
            comp_raw <= ~raw;
            repeat (3) @(negedge clk);
            chk({31'h0, comparator_result}, {31'h0, raw ^ inv});
            @(negedge clk);
            chk({31'h0, comparator_result}, {31'h0, ~raw ^ inv});
        end
        $display("test result done");
        apb(1'b1, A_CMP, 32'h1, rd, er);
        settle(n);
        chk({31'h0, n >= SETTLE_CYCLES - 4 && n <= SETTLE_CYCLES + 4}, 32'h1);
        apb(1'b0, A_CMP, 32'h0, rd, er);
        apb(1'b1, A_FLAG, 32'h0, rd, er);
        @(negedge clk);
        chk({31'h0, comparator_change_flag}, 32'h0);
        apb(1'b1, A_CMP, 32'h2, rd, er);
        repeat (5) @(negedge clk);
        chk({31'h0, result_valid}, 32'h0);
        @(posedge clk);
        comp_raw <= ~comp_raw;
        repeat (40) @(negedge clk);
        chk({31'h0, comparator_change_flag}, 32'h0);
        settle(n);
        repeat (3) @(negedge clk);
        chk({31'h0, comparator_change_flag}, 32'h1);
        apb(1'b1, A_FLAG, 32'h0, rd, er);
        @(negedge clk);
        chk({31'h0, comparator_change_flag}, 32'h1);
        apb(1'b0, A_CMP, 32'h0, rd, er);
        apb(1'b1, A_FLAG, 32'h0, rd, er);
        @(negedge clk);
        chk({31'h0, comparator_change_flag}, 32'h0);
        apb(1'b1, A_FLAG, 32'h1, rd, er);
        rd_chk(A_FLAG, 32'h1);
        apb(1'b1, A_FLAG, 32'h0, rd, er);
        rd_chk(A_FLAG, 32'h0);
        $display("test flag done");
        @(posedge clk);
        ce <= 1'b0;
        comp_raw <= ~comp_raw;
        repeat (6) @(negedge clk);
        chk({31'h0, comparator_result}, {31'h0, ~comp_raw});
        @(posedge clk);
        ce <= 1'b1;
        repeat (4) @(negedge clk);
        chk({31'h0, comparator_result}, {31'h0, comp_raw});
        $display("test enable done");
        apb(1'b1, 12'h100, 32'hFF, rd, er);
        apb(1'b0, 12'h100, 32'h0, rd, er);
        chk({er, rd[30:0]}, 32'h80000000);
        rd_chk(A_REF, {24'h0, last_ref[7:0] & REF_WMASK});
        $display("test unmapped done");
        report_and_stop();
    end
endmodule
